// ==== rtl/led_pwm_params.svh ====
`ifndef LED_PWM_PARAMS_SVH
`define LED_PWM_PARAMS_SVH

// Serial slave address
`define DEV_ADDR 7'h36

// Internal register addresses
`define REG_GENERAL 8'h10
`define REG_MAIN 8'hA0
`define REG_IND 8'hC0

// Power-on values
`define RST_GENERAL 8'h20
`define RST_MAIN 8'hE0
`define RST_IND 8'hFC

// General control field positions
`define GEN_MAIN_EN 0
`define GEN_TEST_LO 1
`define GEN_IND_EN 3
`define GEN_SENSE_EN 5
`define GEN_TEST_HI 6

// Writable bits of each register
`define GEN_WMASK 8'h6B
`define MAIN_WMASK 8'h1F
`define IND_WMASK 8'h03

// Dimming timing
`define CLK_HZ 20000000
`define PWM_HZ 20000
`define PWM_PERIOD_CYC (`CLK_HZ / `PWM_HZ)
`define PWM_HALF_SLOT (`PWM_PERIOD_CYC / 8)
`define PWM_SLOTS 16

`endif

// ==== rtl/led_pwm_pkg.sv ====
package led_pwm_pkg;

   // Serial link phases, receive and transmit
   typedef enum logic [2:0] {
      LS_IDLE,
      LS_ADDR,
      LS_REG,
      LS_DATA,
      LS_ACK,
      LS_TX,
      LS_TXACK
   } link_state_t;

   // Analog current fraction of full scale, ascending
   typedef enum logic [1:0] {
      LVL_20,
      LVL_40,
      LVL_70,
      LVL_100
   } analog_level_t;

endpackage

// ==== rtl/bit_sync.sv ====
`timescale 1ns/1ps

// ****************************************
// Two-stage level synchroniser
// ****************************************
module bit_sync (
   input wire logic clk, // Destination clock
   input wire logic d,   // Asynchronous level
   output logic q        // Synchronised level
);

   logic meta_r;

   // First stage feeds only the second
   always_ff @(posedge clk) begin
      meta_r <= d;
      q <= meta_r;
   end

endmodule // bit_sync

// ==== rtl/pwm_dimmer.sv ====
`timescale 1ns/1ps
`include "led_pwm_params.svh"

// ****************************************
// Main group mixed analog and PWM dimmer
// ****************************************
module pwm_dimmer
   import led_pwm_pkg::*;
(
   input wire logic clk,           // System clock
   input wire logic resetn,        // Synchronous reset, active low
   input wire logic enable,        // Main group enable
   input wire logic [4:0] code,    // Main level code
   output logic sink_on,           // Gated sink drive
   output analog_level_t level     // Analog current select
);

   logic [9:0] phase_r;
   logic [4:0] code_r;
   logic [4:0] duty;
   analog_level_t lvl;
   logic [11:0] thresh;

   // Code to analog level and on-slots
   always_comb begin
      if (code_r < 5'h10) begin
         lvl = LVL_20;
         duty = code_r + 5'h01;
      end else if (code_r < 5'h17) begin
         lvl = LVL_40;
         duty = code_r - 5'h06;
      end else if (code_r < 5'h1D) begin
         lvl = LVL_70;
         duty = code_r - 5'h0C;
      end else begin
         lvl = LVL_100;
         case (code_r)
            5'h1D: duty = 5'h0D;
            5'h1E: duty = 5'h0F;
            default: duty = 5'h10;
         endcase
      end
   end

   // Each slot spans one half-slot unit of the doubled phase
   assign thresh = 12'(duty) * 12'(`PWM_HALF_SLOT);

   // Fixed-rate period counter
   always_ff @(posedge clk) begin
      if (!resetn || phase_r == 10'(`PWM_PERIOD_CYC - 1)) begin
         phase_r <= 10'h000;
      end else begin
         phase_r <= phase_r + 10'h001;
      end
   end

   // New code taken only at the period boundary
   always_ff @(posedge clk) begin
      if (!resetn) begin
         code_r <= 5'(`RST_MAIN & `MAIN_WMASK);
      end else if (phase_r == 10'(`PWM_PERIOD_CYC - 1)) begin
         code_r <= code;
      end
   end

   // Sink gate and analog level
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sink_on <= 1'b0;
         level <= LVL_20;
      end else begin
         sink_on <= enable && ({1'b0, phase_r, 1'b0} < thresh);
         level <= lvl;
      end
   end

endmodule // pwm_dimmer

// ==== rtl/led_brightness_pwm_control.sv ====
`timescale 1ns/1ps
`include "led_pwm_params.svh"

// Overview of operation
// - Answer only slave address 36h
// - General control at 10h, resets 20h
// - Main brightness at A0h, resets E0h
// - Indicator brightness at C0h, resets FCh
// - Main enable bit switches main sinks
// - Indicator enable bit switches indicator sink
// - Sense enable bit switches fifth sink sensing
// - Main code is five low bits
// - Main bits seven to five unused
// - Indicator code is two low bits
// - Indicator codes give 20/40/70/100 percent analog
// - Codes 00-0F: 20 percent, duty code+1
// - Codes 10-16 at 40, 17-1C at 70
// - Codes 1D-1F full current, duty 13/15/16
// - PWM repeats at fixed 20 kHz
// - Acknowledge each received byte on ninth clock
// - Reset pin restores defaults, disables outputs

module led_brightness_pwm_control
   import led_pwm_pkg::*;
(
   input wire logic clk,                 // System clock, 20 MHz
   input wire logic resetn,              // Synchronous reset, active low
   input wire logic link_clk,            // Serial sampling clock
   input wire logic scl,                 // Serial clock pin
   input wire logic sda_in,              // Serial data pin level
   output logic sda_out,                 // Serial data drive value
   output logic sda_oe,                  // Serial data drive enable
   output logic main_sink_on,            // Main group sinks on
   output analog_level_t main_level,     // Main group analog level
   output logic indicator_sink_on,       // Indicator sink on
   output analog_level_t indicator_level, // Indicator analog level
   output logic fifth_sense_on           // Fifth sink sensing on
);

   // ****************************************
   // Shared helpers
   // ****************************************

   // Keep written bits that exist, others at their reset value
   function automatic logic [7:0] merge(input logic [7:0] wdata, input logic [7:0] mask,
                                        input logic [7:0] rst);
      merge = (wdata & mask) | (rst & ~mask);
   endfunction

   // ****************************************
   // Link domain: pin and reset synchronisers
   // ****************************************

   logic scl_s;
   logic sda_s;
   logic lrstn_s;
   logic scl_d_r;
   logic sda_d_r;

   bit_sync u_sync_scl (
      .clk(link_clk),
      .d(scl),
      .q(scl_s)
   );

   bit_sync u_sync_sda (
      .clk(link_clk),
      .d(sda_in),
      .q(sda_s)
   );

   bit_sync u_sync_lrst (
      .clk(link_clk),
      .d(resetn),
      .q(lrstn_s)
   );

   // Previous synchronised levels for edge detection
   always_ff @(posedge link_clk) begin
      if (!lrstn_s) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // Bus events; start and stop need the clock high
   assign scl_rise = scl_s && !scl_d_r;
   assign scl_fall = !scl_s && scl_d_r;
   assign start_seen = scl_s && scl_d_r && sda_d_r && !sda_s;
   assign stop_seen = scl_s && scl_d_r && !sda_d_r && sda_s;

   // ****************************************
   // Link domain: byte engine
   // ****************************************

   link_state_t state_r;
   link_state_t after_ack_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] rx_sh_r;
   logic [7:0] tx_sh_r;
   logic [7:0] ptr_r;
   logic master_nack_r;
   logic wr_tog_r;
   logic [7:0] wr_ptr_r;
   logic [7:0] wr_data_r;
   logic [7:0] gen_m_r;
   logic [7:0] main_m_r;
   logic [7:0] ind_m_r;
   logic [7:0] rd_data;
   logic byte_done;

   assign byte_done = scl_fall && (bit_cnt_r == 4'h8);

   // Read-back mux over the link-side copy of the registers
   always_comb begin
      case (ptr_r)
         `REG_GENERAL: rd_data = gen_m_r;
         `REG_MAIN: rd_data = main_m_r;
         `REG_IND: rd_data = ind_m_r;
         default: rd_data = 8'h00;
      endcase
   end

   // Serial shift-in of address, register and data bytes
   always_ff @(posedge link_clk) begin
      if (!lrstn_s) begin
         rx_sh_r <= 8'h00;
      end else if (scl_rise && (state_r == LS_ADDR || state_r == LS_REG || state_r == LS_DATA)) begin
         rx_sh_r <= {rx_sh_r[6:0], sda_s};
      end
   end

   // Master acknowledge sampled after each sent byte
   always_ff @(posedge link_clk) begin
      if (!lrstn_s) begin
         master_nack_r <= 1'b1;
      end else if (scl_rise && state_r == LS_TXACK) begin
         master_nack_r <= sda_s;
      end
   end

   // Protocol state, bit counter and data line drive
   always_ff @(posedge link_clk) begin
      if (!lrstn_s) begin
         state_r <= LS_IDLE;
         after_ack_r <= LS_IDLE;
         bit_cnt_r <= 4'h0;
         ptr_r <= 8'h00;
         tx_sh_r <= 8'h00;
         sda_oe <= 1'b0;
      end else if (start_seen) begin
         state_r <= LS_ADDR;
         bit_cnt_r <= 4'h0;
         sda_oe <= 1'b0;
      end else if (stop_seen) begin
         state_r <= LS_IDLE;
         sda_oe <= 1'b0;
      end else if (scl_rise) begin
         case (state_r)
            LS_ADDR, LS_REG, LS_DATA: begin
               bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            default: begin
               bit_cnt_r <= bit_cnt_r;
            end
         endcase
      end else if (scl_fall) begin
         case (state_r)
            LS_ADDR: begin
               if (byte_done) begin
                  bit_cnt_r <= 4'h0;
                  if (rx_sh_r[7:1] == `DEV_ADDR) begin
                     sda_oe <= 1'b1;
                     after_ack_r <= rx_sh_r[0] ? LS_TX : LS_REG;
                     state_r <= LS_ACK;
                  end else begin
                     state_r <= LS_IDLE;
                  end
               end
            end
            LS_REG: begin
               if (byte_done) begin
                  bit_cnt_r <= 4'h0;
                  ptr_r <= rx_sh_r;
                  sda_oe <= 1'b1;
                  after_ack_r <= LS_DATA;
                  state_r <= LS_ACK;
               end
            end
            LS_DATA: begin
               if (byte_done) begin
                  bit_cnt_r <= 4'h0;
                  sda_oe <= 1'b1;
                  after_ack_r <= LS_DATA;
                  state_r <= LS_ACK;
               end
            end
            LS_ACK: begin
               if (after_ack_r == LS_TX) begin
                  tx_sh_r <= {rd_data[6:0], 1'b1};
                  sda_oe <= !rd_data[7];
                  bit_cnt_r <= 4'h1;
               end else begin
                  sda_oe <= 1'b0;
                  bit_cnt_r <= 4'h0;
               end
               state_r <= after_ack_r;
            end
            LS_TX: begin
               if (bit_cnt_r == 4'h8) begin
                  sda_oe <= 1'b0;
                  state_r <= LS_TXACK;
               end else begin
                  sda_oe <= !tx_sh_r[7];
                  tx_sh_r <= {tx_sh_r[6:0], 1'b1};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end
            end
            LS_TXACK: begin
               if (master_nack_r) begin
                  state_r <= LS_IDLE;
               end else begin
                  tx_sh_r <= {rd_data[6:0], 1'b1};
                  sda_oe <= !rd_data[7];
                  bit_cnt_r <= 4'h1;
                  state_r <= LS_TX;
               end
            end
            default: begin
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // Data line is only ever pulled low
   always_ff @(posedge link_clk) begin
      sda_out <= 1'b0;
   end

   // Completed data byte: hand over word and update the link copy
   always_ff @(posedge link_clk) begin
      if (!lrstn_s) begin
         wr_tog_r <= 1'b0;
         wr_ptr_r <= 8'h00;
         wr_data_r <= 8'h00;
         gen_m_r <= `RST_GENERAL;
         main_m_r <= `RST_MAIN;
         ind_m_r <= `RST_IND;
      end else if (byte_done && state_r == LS_DATA) begin
         wr_tog_r <= !wr_tog_r;
         wr_ptr_r <= ptr_r;
         wr_data_r <= rx_sh_r;
         case (ptr_r)
            `REG_GENERAL: gen_m_r <= merge(rx_sh_r, `GEN_WMASK, `RST_GENERAL);
            `REG_MAIN: main_m_r <= merge(rx_sh_r, `MAIN_WMASK, `RST_MAIN);
            `REG_IND: ind_m_r <= merge(rx_sh_r, `IND_WMASK, `RST_IND);
            default: ;
         endcase
      end
   end

   // ****************************************
   // System domain: write crossing
   // ****************************************

   logic wr_tog_s;
   logic wr_tog_d_r;
   logic wr_take;

   bit_sync u_sync_wr (
      .clk(clk),
      .d(wr_tog_r),
      .q(wr_tog_s)
   );

   // Toggle edge marks a new stable word
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_tog_d_r <= 1'b0;
      end else begin
         wr_tog_d_r <= wr_tog_s;
      end
   end

   assign wr_take = wr_tog_s ^ wr_tog_d_r;

   // ****************************************
   // System domain: control registers
   // ****************************************

   logic [7:0] gen_r;
   logic [7:0] main_r;
   logic [7:0] ind_r;

   // General control register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         gen_r <= `RST_GENERAL;
      end else if (wr_take && wr_ptr_r == `REG_GENERAL) begin
         gen_r <= merge(wr_data_r, `GEN_WMASK, `RST_GENERAL);
      end
   end

   // Main brightness register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         main_r <= `RST_MAIN;
      end else if (wr_take && wr_ptr_r == `REG_MAIN) begin
         main_r <= merge(wr_data_r, `MAIN_WMASK, `RST_MAIN);
      end
   end

   // Indicator brightness register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ind_r <= `RST_IND;
      end else if (wr_take && wr_ptr_r == `REG_IND) begin
         ind_r <= merge(wr_data_r, `IND_WMASK, `RST_IND);
      end
   end

   // ****************************************
   // System domain: sink controls
   // ****************************************

   pwm_dimmer u_dimmer (
      .clk(clk),
      .resetn(resetn),
      .enable(gen_r[`GEN_MAIN_EN]),
      .code(main_r[4:0]),
      .sink_on(main_sink_on),
      .level(main_level)
   );

   // Indicator sink, analog levels only
   always_ff @(posedge clk) begin
      if (!resetn) begin
         indicator_sink_on <= 1'b0;
         indicator_level <= LVL_20;
      end else begin
         indicator_sink_on <= gen_r[`GEN_IND_EN];
         indicator_level <= analog_level_t'(ind_r[1:0]);
      end
   end

   // Fifth main sink voltage sensing
   always_ff @(posedge clk) begin
      if (!resetn) begin
         fifth_sense_on <= 1'b0;
      end else begin
         fifth_sense_on <= gen_r[`GEN_SENSE_EN];
      end
   end

endmodule // led_brightness_pwm_control

// ==== tb/led_brightness_pwm_control_properties.sv ====
`timescale 1ns/1ps
// ****
// Port checker
// ****
module led_pwm_checker
   import led_pwm_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic resetn, // Reset, low
   input wire logic link_clk, // Link clock
   input wire logic scl, // Serial clock
   input wire logic sda_in, // Data wire
   input wire logic sda_out, // Data value
   input wire logic sda_oe, // Data enable
   input wire logic main_sink_on, // Main drive
   input wire analog_level_t main_level, // Main level
   input wire logic indicator_sink_on, // Indicator
   input wire analog_level_t indicator_level, // Level
   input wire logic fifth_sense_on // Sensing
);
   logic prev_r;
   logic [1:0] rise_cnt_r; // Rises since the sink was last dark for 1000 cycles, saturating at 2
   logic [9:0] gap_r;
   logic [10:0] low_r;
   // Cycles since last rise; long dark runs forget it
   always_ff @(posedge clk) begin
      if (!resetn) begin
         prev_r <= 1'b0;
         rise_cnt_r <= 2'h0;
         gap_r <= 10'h000;
         low_r <= 11'h000;
      end else begin
         prev_r <= main_sink_on;
         gap_r <= (main_sink_on && !prev_r) ? 10'h000 : ((gap_r == 10'h3E7) ? 10'h000 : gap_r + 10'h001);
         low_r <= main_sink_on ? 11'h000 : ((low_r == 11'h3E8) ? low_r : low_r + 11'h001);
         // An enable may land mid-period, so only later rises mark period starts
         if (main_sink_on && !prev_r) begin
            rise_cnt_r <= (rise_cnt_r == 2'h2) ? rise_cnt_r : rise_cnt_r + 2'h1;
         end else if (low_r == 11'h3E8) begin
            rise_cnt_r <= 2'h0;
         end
      end
   end
   property p_open_drain;
      @(posedge link_clk) disable iff (!resetn) sda_oe |-> !sda_out;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("data driven high");
   property p_oe_scl_low;
      @(posedge link_clk) disable iff (!resetn) $changed(sda_oe) |-> !scl;
   endproperty
   a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved, clock high");
   property p_ack_hold;
      @(posedge link_clk) disable iff (!resetn) $rose(sda_oe) |-> sda_oe[*8];
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("short acknowledge");
   property p_reset_link;
      @(posedge link_clk) (!resetn)[*6] |-> !sda_oe;
   endproperty
   a_reset_link: assert property (p_reset_link) else $error("drive in reset");
   property p_reset_clk;
      @(posedge clk) !resetn |=> !main_sink_on && !indicator_sink_on && !fifth_sense_on
         && main_level == LVL_20 && indicator_level == LVL_20;
   endproperty
   a_reset_clk: assert property (p_reset_clk) else $error("outputs on in reset");
   property p_defaults;
      @(posedge clk) disable iff (!resetn) $rose(resetn) |-> ##[1:2] fifth_sense_on && !main_sink_on;
   endproperty
   a_defaults: assert property (p_defaults) else $error("bad default state");
   property p_period;
      @(posedge clk) disable iff (!resetn) $rose(main_sink_on) && rise_cnt_r == 2'h2 |-> gap_r == 10'h3E7;
   endproperty
   a_period: assert property (p_period) else $error("period not 1000");
   property p_min_on;
      @(posedge clk) disable iff (!resetn) $rose(main_sink_on) && rise_cnt_r != 2'h0 |-> main_sink_on[*8];
   endproperty
   a_min_on: assert property (p_min_on) else $error("runt pulse");
   property p_level_edge;
      @(posedge clk) disable iff (!resetn) $changed(main_level) && $past(main_sink_on) |-> main_sink_on;
   endproperty
   a_level_edge: assert property (p_level_edge) else $error("level mid period");
   c_ack: cover property (@(posedge link_clk) $rose(sda_oe));
   c_pwm: cover property (@(posedge clk) $rose(main_sink_on));
   c_full: cover property (@(posedge clk) main_level == LVL_100 && main_sink_on);
endmodule // led_pwm_checker

bind led_brightness_pwm_control led_pwm_checker i_checker (.clk(clk), .resetn(resetn), .link_clk(link_clk),
   .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .main_sink_on(main_sink_on),
   .main_level(main_level), .indicator_sink_on(indicator_sink_on), .indicator_level(indicator_level),
   .fifth_sense_on(fifth_sense_on));

// ==== tb/serial_host_model.sv ====
`timescale 1ns/1ps
// ****
// Serial bus master
// ****
module serial_host_model (
   input wire logic link_clk, // Sampling clock
   input wire logic sda_in, // Resolved wire
   output logic scl, // Clock, idle high
   output logic sda_drv // Drive, 1 releases
);
   int q = 4;
   // Idle bus at time zero
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // Wait link edges
   task automatic tick(input int n);
      repeat (n) @(posedge link_clk);
   endtask
   // One pulse; data moves only while clock low
   task automatic xfer(input logic b, output logic r);
      sda_drv <= b;
      tick(q);
      scl <= 1'b1;
      tick(q);
      r = sda_in;
      tick(q);
      scl <= 1'b0;
      tick(q);
   endtask
   // Start or repeated start
   task automatic begin_frame;
      tick(1);
      sda_drv <= 1'b1;
      tick(q);
      scl <= 1'b1;
      tick(q);
      sda_drv <= 1'b0;
      tick(q);
      scl <= 1'b0;
      tick(q);
   endtask
   // Stop, bus released
   task automatic end_frame;
      sda_drv <= 1'b0;
      tick(q);
      scl <= 1'b1;
      tick(q);
      sda_drv <= 1'b1;
      tick(q);
   endtask
   // Byte out MSB first, ninth pulse for acknowledge
   task automatic send(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(b[i], r);
      xfer(1'b1, r);
      ack = !r;
   endtask
   // Byte in, then release to end the read
   task automatic recv(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
      xfer(1'b1, r);
   endtask
   task automatic write_reg(input logic [7:0] r, input logic [7:0] d, output logic [2:0] a);
      begin_frame();
      send({7'h36, 1'b0}, a[2]);
      send(r, a[1]);
      send(d, a[0]);
      end_frame();
   endtask
   task automatic read_reg(input logic [7:0] r, output logic [7:0] d);
      logic a;
      begin_frame();
      send(8'h6C, a);
      send(r, a);
      begin_frame();
      send(8'h6D, a);
      recv(d);
      end_frame();
   endtask
   task automatic probe(input logic [6:0] adr, output logic ack);
      begin_frame();
      send({adr, 1'b0}, ack);
      end_frame();
   endtask
endmodule // serial_host_model

// ==== tb/led_brightness_pwm_control_tb_top.sv ====
`timescale 1ns/1ps
// ****
// Bench top
// ****
module led_brightness_pwm_control_tb_top
   import led_pwm_pkg::*;
;
   logic clk, link_clk, resetn, scl, sda_drv, sda_in, sda_out, sda_oe;
   logic main_sink_on, indicator_sink_on, fifth_sense_on;
   analog_level_t main_level, indicator_level;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   // Open-drain wire with pull-up
   assign sda_in = sda_drv & ((sda_oe === 1'b1) ? sda_out : 1'b1);
   // Clocks; edges coincide every 150 ns
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #2;
      forever #6 link_clk = ~link_clk;
   end
   led_brightness_pwm_control i_dut (.clk(clk), .resetn(resetn), .link_clk(link_clk), .scl(scl),
      .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .main_sink_on(main_sink_on),
      .main_level(main_level), .indicator_sink_on(indicator_sink_on),
      .indicator_level(indicator_level), .fifth_sense_on(fifth_sense_on));
   serial_host_model i_host (.link_clk(link_clk), .sda_in(sda_in), .scl(scl), .sda_drv(sda_drv));
   task stop_test;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         num_errors++;
         stop_test();
      end
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask
   task wr(input logic [7:0] r, input logic [7:0] d);
      logic [2:0] a;
      i_host.write_reg(r, d, a);
      chk(8'(a), 8'h07);
   endtask
   task rd(input logic [7:0] r, input logic [7:0] exp);
      logic [7:0] d;
      i_host.read_reg(r, d);
      chk(d, exp);
   endtask
   task t_reset_values;
      rd(8'h10, 8'h20);
      rd(8'hA0, 8'hE0);
      rd(8'hC0, 8'hFC);
      chk(8'(fifth_sense_on), 8'h01);
      chk(8'({main_sink_on, indicator_sink_on}), 8'h00);
   endtask
   task t_address;
      logic ack;
      logic [6:0] a [4] = '{7'h36, 7'h37, 7'h16, 7'h76};
      for (int i = 0; i < 4; i++) begin
         i_host.probe(a[i], ack);
         chk(8'(ack), (i == 0) ? 8'h01 : 8'h00);
      end
   endtask
   task t_general;
      wr(8'h10, 8'h9D);
      wait_clk(6);
      chk(8'({indicator_sink_on, fifth_sense_on}), 8'h02);
      rd(8'h10, 8'h09);
      wr(8'h55, 8'hAA);
      rd(8'h55, 8'h00);
      wr(8'h10, 8'h20);
      wait_clk(6);
      chk(8'({indicator_sink_on, fifth_sense_on}), 8'h01);
      wait_clk(1100);
   endtask
   task t_indicator;
      for (int c = 0; c < 4; c++) begin
         wr(8'hC0, 8'(c));
         wait_clk(6);
         chk(8'(indicator_level), 8'(c));
         rd(8'hC0, 8'hFC | 8'(c));
      end
   endtask
   task t_main;
      logic [7:0] codes [10] = '{8'h00, 8'h0F, 8'h10, 8'h16, 8'h17, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'hE5};
      logic [4:0] c;
      analog_level_t lv;
      int n, on;
      wr(8'h10, 8'h21);
      for (int i = 0; i < 10; i++) begin
         c = codes[i][4:0];
         if (c < 5'h10) begin
            lv = LVL_20;
            n = c + 1;
         end else if (c < 5'h17) begin
            lv = LVL_40;
            n = c - 6;
         end else if (c < 5'h1D) begin
            lv = LVL_70;
            n = c - 12;
         end else begin
            lv = LVL_100;
            n = (c == 5'h1D) ? 13 : ((c == 5'h1E) ? 15 : 16);
         end
         wr(8'hA0, codes[i]);
         wait_clk(2100);
         on = 0;
         repeat (1000) begin
            @(negedge clk);
            on += (main_sink_on === 1'b1);
         end
         chk(8'(main_level), 8'(lv));
         chk(8'((2 * on > n * 125 - 3) && (2 * on < n * 125 + 3)), 8'h01);
      end
      rd(8'hA0, 8'hE5);
      wr(8'h10, 8'h20);
      wait_clk(4);
      chk(8'(main_sink_on), 8'h00);
   endtask
   task t_reset_pin;
      i_host.q = 9;
      wr(8'h10, 8'h08);
      wr(8'hC0, 8'h03);
      @(posedge clk);
      resetn <= 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      wait_clk(4);
      chk(8'(indicator_sink_on), 8'h00);
      rd(8'h10, 8'h20);
      rd(8'hC0, 8'hFC);
   endtask
   // Main sequence
   initial begin
      resetn = 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      wait_clk(4);
      t_reset_values();
      t_address();
      t_general();
      t_indicator();
      t_main();
      t_reset_pin();
      stop_test();
   end
endmodule // led_brightness_pwm_control_tb_top
